// [rtl/demand_shaper.sv]
`timescale 1ns/10ps
module demand_shaper
  import dmd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] duty_in,
  input  wire logic        duty_valid,
  input  wire logic [15:0] pos_in,
  input  wire logic        pos_valid,
  output logic      [15:0] demand,
  output logic             demand_valid,
  output logic             duty_low_fault,
  output logic             duty_high_fault,
  output logic      [15:0] throttle_position_feedback_output,
  output logic      [15:0] ao_mv,
  output logic             cfg_error
);

  state_s r_ff;
  state_s nxt_r;

  // saturate a write into the documented range of that field
  function automatic logic [15:0] sat_cfg(input logic [4:0]  ix,
                                          input logic [31:0] d);
    logic [15:0] v;
    v = (d[31:16] != 16'h0000) ? 16'hFFFF : d[15:0];
    if (v < CFG_MIN[ix]) v = CFG_MIN[ix];
    if (v > CFG_MAX[ix]) v = CFG_MAX[ix];
    return v;
  endfunction : sat_cfg

  function automatic logic incr(input pts_t p);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (p[i+1] <= p[i]) ok = 1'b0;
    end
    return ok;
  endfunction : incr

  // first segment whose upper point lies above x, else the last one
  function automatic logic [2:0] seg_sel(input logic [15:0] x,
                                         input pts_t        p);
    logic [2:0] s;
    s = 3'h3;
    for (int i = 3; i >= 0; i--) begin
      if (x < p[i+1]) s = 3'(i);
    end
    return s;
  endfunction : seg_sel

  pts_t        bp;
  pts_t        cv;
  logic        curve_ok;
  logic        use_curve;
  logic        addr_ok;
  logic [4:0]  a_idx;

  assign bp        = r_ff.cfg[IX_BP0 +: 5];
  assign cv        = r_ff.cfg[IX_CV0 +: 5];
  assign curve_ok  = incr(bp);
  assign use_curve = r_ff.cfg[IX_CTRL][CTRL_CURVE] && curve_ok;
  assign addr_ok   = (haddr[31:7] == 25'h0000000);
  assign a_idx     = haddr[6:2];

  always_comb begin
    logic [15:0] x;
    logic [15:0] x0;
    logic [15:0] x1;
    logic [15:0] y0;
    logic [15:0] y1;
    logic [15:0] t;
    logic [15:0] res;
    logic [16:0] rem_t;
    logic [31:0] prod;
    logic [2:0]  s;
    x     = 16'h0000;
    x0    = 16'h0000;
    x1    = 16'h0000;
    y0    = 16'h0000;
    y1    = 16'h0000;
    t     = 16'h0000;
    res   = 16'h0000;
    rem_t = 17'h00000;
    prod  = 32'h00000000;
    s     = 3'h0;
    nxt_r            = r_ff;
    nxt_r.demand_vld = 1'b0;
    nxt_r.cfg_err    = !curve_ok;
    nxt_r.hreadyout  = 1'b1;
    nxt_r.hresp      = 1'b0;

    // write data phase; unmapped writes are dropped
    nxt_r.wr_pend = 1'b0;
    if (r_ff.wr_pend && (r_ff.wr_idx < NCFG_IX)) begin
      nxt_r.cfg[r_ff.wr_idx] = sat_cfg(r_ff.wr_idx, hwdata);
    end
    // address phase; reads see a write still in its data phase
    if (hready && hsel && htrans[1]) begin
      if (hwrite) begin
        nxt_r.wr_pend = addr_ok;
        nxt_r.wr_idx  = a_idx;
      end else begin
        nxt_r.hrdata = 32'h00000000;
        if (addr_ok && (a_idx < NCFG_IX)) begin
          nxt_r.hrdata[15:0] = nxt_r.cfg[a_idx];
        end else if (addr_ok && (a_idx == IX_STATUS)) begin
          nxt_r.hrdata[ST_FLT_LO]  = r_ff.flt_lo;
          nxt_r.hrdata[ST_FLT_HI]  = r_ff.flt_hi;
          nxt_r.hrdata[ST_CFG_ERR] = r_ff.cfg_err;
          nxt_r.hrdata[ST_BUSY]    = (r_ff.st != ST_IDLE);
        end else if (addr_ok && (a_idx == IX_DEMAND)) begin
          nxt_r.hrdata[15:0] = r_ff.demand;
        end else if (addr_ok && (a_idx == IX_FBACK)) begin
          nxt_r.hrdata[15:0] = r_ff.fb;
        end
      end
    end

    if (duty_valid) begin
      nxt_r.duty_smp = duty_in;
      nxt_r.pend_d   = 1'b1;
      nxt_r.flt_lo   = (duty_in <= r_ff.cfg[IX_FLT_LO]);
      nxt_r.flt_hi   = (duty_in >= r_ff.cfg[IX_FLT_HI]);
    end
    if (pos_valid) begin
      nxt_r.pos_smp = pos_in;
      nxt_r.pend_p  = 1'b1;
    end

    case (r_ff.st)
      ST_IDLE: begin
        // demand path first; a new sample in this cycle keeps pending set
        if (r_ff.pend_d) begin
          nxt_r.job    = JB_SCALE;
          nxt_r.st     = ST_LOAD;
          nxt_r.pend_d = duty_valid;
        end else if (r_ff.pend_p) begin
          nxt_r.st     = ST_LOAD;
          nxt_r.pend_p = pos_valid;
          if (use_curve) begin
            nxt_r.job = JB_INV;
          end else begin
            nxt_r.job = JB_VOLT;
            nxt_r.fb  = r_ff.pos_smp;
          end
        end
      end
      ST_LOAD: begin
        case (r_ff.job)
          JB_SCALE: begin
            x  = r_ff.duty_smp;
            x0 = r_ff.cfg[IX_DUTY_LO];
            x1 = r_ff.cfg[IX_DUTY_HI];
            y0 = r_ff.cfg[IX_DEM_LO];
            y1 = r_ff.cfg[IX_DEM_HI];
          end
          JB_CURVE: begin
            s  = seg_sel(r_ff.scaled, bp);
            x  = r_ff.scaled;
            x0 = bp[s];
            x1 = bp[3'(s + 3'h1)];
            y0 = cv[s];
            y1 = cv[3'(s + 3'h1)];
          end
          JB_INV: begin
            s  = seg_sel(r_ff.pos_smp, cv);
            x  = r_ff.pos_smp;
            x0 = cv[s];
            x1 = cv[3'(s + 3'h1)];
            y0 = bp[s];
            y1 = bp[3'(s + 3'h1)];
          end
          default: begin
            x  = r_ff.fb;
            x0 = r_ff.cfg[IX_AOP_LO];
            x1 = r_ff.cfg[IX_AOP_HI];
            y0 = r_ff.cfg[IX_MV_LO];
            y1 = r_ff.cfg[IX_MV_HI];
          end
        endcase
        if (x0 > x1) begin
          t  = x0;
          x0 = x1;
          x1 = t;
          t  = y0;
          y0 = y1;
          y1 = t;
        end
        // clamp outside span; equal points never divide
        nxt_r.quo = 28'h0000000;
        nxt_r.neg = 1'b0;
        if (x <= x0) begin
          nxt_r.base = y0;
          nxt_r.st   = ST_STORE;
        end else if (x >= x1) begin
          nxt_r.base = y1;
          nxt_r.st   = ST_STORE;
        end else begin
          nxt_r.neg  = (y1 < y0);
          prod       = (x - x0) * ((y1 < y0) ? (y0 - y1) : (y1 - y0));
          nxt_r.num  = prod[27:0];
          nxt_r.den  = x1 - x0;
          nxt_r.rem  = 17'h00000;
          nxt_r.base = y0;
          nxt_r.cnt  = DIV_LAST;
          nxt_r.st   = ST_DIV;
        end
      end
      ST_DIV: begin
        // restoring divide, one quotient bit a cycle to save area
        rem_t     = {r_ff.rem[15:0], r_ff.num[27]};
        nxt_r.num = {r_ff.num[26:0], 1'b0};
        if (rem_t >= {1'b0, r_ff.den}) begin
          nxt_r.rem = rem_t - {1'b0, r_ff.den};
          nxt_r.quo = {r_ff.quo[26:0], 1'b1};
        end else begin
          nxt_r.rem = rem_t;
          nxt_r.quo = {r_ff.quo[26:0], 1'b0};
        end
        if (r_ff.cnt == 5'h00) begin
          nxt_r.st = ST_STORE;
        end else begin
          nxt_r.cnt = r_ff.cnt - 5'h01;
        end
      end
      ST_STORE: begin
        // quotient never exceeds the output span, so no wrap here
        res = r_ff.neg ? (r_ff.base - r_ff.quo[15:0])
                       : (r_ff.base + r_ff.quo[15:0]);
        nxt_r.st = ST_IDLE;
        case (r_ff.job)
          JB_SCALE: begin
            nxt_r.scaled = res;
            if (use_curve) begin
              nxt_r.job = JB_CURVE;
              nxt_r.st  = ST_LOAD;
            end else begin
              nxt_r.demand     = res;
              nxt_r.demand_vld = 1'b1;
            end
          end
          JB_CURVE: begin
            nxt_r.demand     = res;
            nxt_r.demand_vld = 1'b1;
          end
          JB_INV: begin
            nxt_r.fb  = res;
            nxt_r.job = JB_VOLT;
            nxt_r.st  = ST_LOAD;
          end
          default: begin
            nxt_r.ao_mv = res;
          end
        endcase
      end
      default: begin
        nxt_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_ff           <= '0;
      r_ff.st        <= ST_IDLE;
      r_ff.job       <= JB_SCALE;
      // curve starts off with all defaults
      r_ff.cfg       <= CFG_RESET;
      r_ff.hreadyout <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign hrdata                            = r_ff.hrdata;
  assign hreadyout                         = r_ff.hreadyout;
  assign hresp                             = r_ff.hresp;
  assign demand                            = r_ff.demand;
  assign demand_valid                      = r_ff.demand_vld;
  assign duty_low_fault                    = r_ff.flt_lo;
  assign duty_high_fault                   = r_ff.flt_hi;
  assign throttle_position_feedback_output = r_ff.fb;
  assign ao_mv                             = r_ff.ao_mv;
  assign cfg_error                         = r_ff.cfg_err;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  duty_lo_range_a: assert property (
    r_ff.cfg[IX_DUTY_LO] >= 16'h01F4 && r_ff.cfg[IX_DUTY_LO] <= 16'h251C)
    else $error("low duty point out of range");
  duty_hi_range_a: assert property (
    r_ff.cfg[IX_DUTY_HI] >= 16'h01F4 && r_ff.cfg[IX_DUTY_HI] <= 16'h251C)
    else $error("high duty point out of range");
  dem_lo_range_a: assert property (
    r_ff.cfg[IX_DEM_LO] <= PCT_MAX)
    else $error("low-end demand out of range");
  low_fault_a: assert property (
    duty_valid |=> r_ff.flt_lo ==
      ($past(duty_in) <= $past(r_ff.cfg[IX_FLT_LO])))
    else $error("low-duty fault wrong after sample");
  high_fault_a: assert property (
    duty_valid |=> r_ff.flt_hi ==
      ($past(duty_in) >= $past(r_ff.cfg[IX_FLT_HI])))
    else $error("high-duty fault wrong after sample");
  curve_bypass_a: assert property (
    r_ff.demand_vld && !$past(use_curve) |-> r_ff.demand == r_ff.scaled)
    else $error("bypassed demand differs from scaled demand");
  curve_order_a: assert property (
    r_ff.st == ST_LOAD && r_ff.job == JB_CURVE |-> incr(bp))
    else $error("curve used with non-increasing breakpoints");
  div_start_a: assert property (
    $rose(r_ff.st == ST_DIV) |-> r_ff.cnt == DIV_LAST)
    else $error("divide started with wrong count");
  div_length_a: assert property (
    r_ff.st == ST_DIV |=> (($past(r_ff.cnt) == 5'h00) ? r_ff.st == ST_STORE
      : (r_ff.st == ST_DIV && r_ff.cnt == $past(r_ff.cnt) - 5'h01)))
    else $error("divide count or length wrong");
  volt_range_a: assert property (
    r_ff.cfg[IX_MV_LO] <= MV_MAX && r_ff.cfg[IX_MV_HI] <= MV_MAX)
    else $error("output voltage point out of range");
  fb_plain_a: assert property (
    r_ff.st == ST_IDLE && !r_ff.pend_d && r_ff.pend_p && !use_curve
      |=> r_ff.fb == $past(r_ff.pos_smp))
    else $error("feedback not equal to position in bypass");

  curve_used_c: cover property (
    r_ff.st == ST_STORE && r_ff.job == JB_CURVE);
  inverse_used_c: cover property (
    r_ff.st == ST_STORE && r_ff.job == JB_INV);
  low_fault_c: cover property ($rose(r_ff.flt_lo));

endmodule : demand_shaper

// [rtl/dmd_pkg.sv]
// Notes on behaviour
// - low duty point, 5..95 %, default 10 %, maps to low-end demand.
// - high duty point, 5..95 %, default 90 %, maps to high-end demand.
// - demand at low duty point, 0..100 %, default 0 %.
// - demand at high duty point, 0..100 %, default 100 %.
// - low-duty fault when measured duty reaches low threshold, 2..50 %.
// - high-duty fault when measured duty reaches high threshold, 50..98 %.
// - curve enable picks curve or bypass; off after reset.
// - five input breakpoints 0..100 %, defaults 0..100 step 25, increasing.
// - five paired output demands 0..100 %, defaults 0,25,50,75,100.
// - with curve on, feedback output is un-curved to track demand input.
// - analog low position point 0..100 %, default 0.
// - analog high position point 0..100 %, default 100.
// - voltage at low position point 0..4.70 V, default 0.5 V.
// - voltage at high position point 0..4.70 V, default 4.5 V.
package dmd_pkg;

  // percent values are in 0.01 % steps, voltages in mV
  localparam int          NCFG       = 21;
  localparam logic [4:0]  NCFG_IX    = 5'h15;
  localparam logic [4:0]  IX_CTRL    = 5'h00;
  localparam logic [4:0]  IX_DUTY_LO = 5'h01;
  localparam logic [4:0]  IX_DUTY_HI = 5'h02;
  localparam logic [4:0]  IX_DEM_LO  = 5'h03;
  localparam logic [4:0]  IX_DEM_HI  = 5'h04;
  localparam logic [4:0]  IX_FLT_LO  = 5'h05;
  localparam logic [4:0]  IX_FLT_HI  = 5'h06;
  localparam logic [4:0]  IX_BP0     = 5'h07;
  localparam logic [4:0]  IX_CV0     = 5'h0C;
  localparam logic [4:0]  IX_AOP_LO  = 5'h11;
  localparam logic [4:0]  IX_AOP_HI  = 5'h12;
  localparam logic [4:0]  IX_MV_LO   = 5'h13;
  localparam logic [4:0]  IX_MV_HI   = 5'h14;
  localparam logic [4:0]  IX_STATUS  = 5'h15;
  localparam logic [4:0]  IX_DEMAND  = 5'h16;
  localparam logic [4:0]  IX_FBACK   = 5'h17;
  localparam int          CTRL_CURVE = 0;
  localparam int          ST_FLT_LO  = 0;
  localparam int          ST_FLT_HI  = 1;
  localparam int          ST_CFG_ERR = 2;
  localparam int          ST_BUSY    = 3;
  localparam logic [4:0]  DIV_LAST   = 5'h1B;
  localparam logic [15:0] MV_MAX     = 16'h125C;
  localparam logic [15:0] PCT_MAX    = 16'h2710;

  typedef logic [0:NCFG-1][15:0] cfg_t;
  typedef logic [0:4][15:0]      pts_t;

  localparam cfg_t CFG_RESET = '{
    16'h0000, 16'h03E8, 16'h2328, 16'h0000, 16'h2710, 16'h00C8, 16'h2648,
    16'h0000, 16'h09C4, 16'h1388, 16'h1D4C, 16'h2710,
    16'h0000, 16'h09C4, 16'h1388, 16'h1D4C, 16'h2710,
    16'h0000, 16'h2710, 16'h01F4, 16'h1194};
  localparam cfg_t CFG_MIN = '{
    16'h0000, 16'h01F4, 16'h01F4, 16'h0000, 16'h0000, 16'h00C8, 16'h1388,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam cfg_t CFG_MAX = '{
    16'h0001, 16'h251C, 16'h251C, 16'h2710, 16'h2710, 16'h1388, 16'h2648,
    16'h2710, 16'h2710, 16'h2710, 16'h2710, 16'h2710,
    16'h2710, 16'h2710, 16'h2710, 16'h2710, 16'h2710,
    16'h2710, 16'h2710, 16'h125C, 16'h125C};

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_DIV, ST_STORE} state_e;
  typedef enum logic [1:0] {JB_SCALE, JB_CURVE, JB_INV, JB_VOLT} job_e;

  typedef struct packed {
    state_e      st;
    job_e        job;
    cfg_t        cfg;
    logic [15:0] duty_smp;
    logic [15:0] pos_smp;
    logic        pend_d;
    logic        pend_p;
    logic [15:0] scaled;
    logic [27:0] num;
    logic [16:0] rem;
    logic [15:0] den;
    logic [27:0] quo;
    logic [4:0]  cnt;
    logic        neg;
    logic [15:0] base;
    logic [15:0] demand;
    logic        demand_vld;
    logic [15:0] fb;
    logic [15:0] ao_mv;
    logic        flt_lo;
    logic        flt_hi;
    logic        cfg_err;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        wr_pend;
    logic [4:0]  wr_idx;
  } state_s;

endpackage : dmd_pkg

// [dv/pwm_host_model.sv]
`timescale 1ns/10ps
module pwm_host_model (
  input  wire logic        clk_sys,
  output logic      [15:0] duty_in,
  output logic             duty_valid,
  output logic      [15:0] pos_in,
  output logic             pos_valid
);
  initial begin
    duty_in    = 16'h0000;
    duty_valid = 1'b0;
    pos_in     = 16'h0000;
    pos_valid  = 1'b0;
  end

  // released data shows the inverse, so a stale value cannot pass
  task automatic send(input logic is_pos, input logic [15:0] v);
    if (is_pos) begin
      pos_in    <= v;
      pos_valid <= 1'b1;
    end else begin
      duty_in    <= v;
      duty_valid <= 1'b1;
    end
    @(posedge clk_sys);
    pos_valid  <= 1'b0;
    duty_valid <= 1'b0;
    if (is_pos) begin
      pos_in <= ~v;
    end else begin
      duty_in <= ~v;
    end
  endtask : send
endmodule : pwm_host_model

// [dv/pwm_demand_scaling_and_curve_test.sv]
`timescale 1ns/10ps
module pwm_demand_scaling_and_curve_test;
  import dmd_pkg::*;
  logic        clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] duty_in, pos_in, demand, fb, ao_mv;
  logic        duty_valid, pos_valid, demand_valid, flt_lo, flt_hi, cfg_error;
  logic [17:0] exp_q[$];
  int          num_errors, n_checks, cyc, seed, d, dm;
  int          duty_pts[10] = '{1000, 9000, 5000, 500, 9500, 100, 9900, 200,
                                9800, 201};
  int          curve_pts[4] = '{3000, 2200, 5000, 4000};

  assign hready = hreadyout;

  demand_shaper demand_shaper_i (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .duty_in(duty_in),
    .duty_valid(duty_valid), .pos_in(pos_in), .pos_valid(pos_valid),
    .demand(demand), .demand_valid(demand_valid),
    .duty_low_fault(flt_lo), .duty_high_fault(flt_hi),
    .throttle_position_feedback_output(fb), .ao_mv(ao_mv),
    .cfg_error(cfg_error));

  pwm_host_model host_i (.clk_sys(clk_sys), .duty_in(duty_in),
    .duty_valid(duty_valid), .pos_in(pos_in), .pos_valid(pos_valid));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [4:0] ix, input logic [31:0] v);
    ahb(1'b1, {25'h0, ix, 2'h0}, v, rd);
  endtask : wr

  task automatic rdchk(input logic [4:0] ix, input logic [31:0] e);
    ahb(1'b0, {25'h0, ix, 2'h0}, 32'h0, rd);
    chk(rd, e);
  endtask : rdchk

  // truncates toward y0, clamps outside the two points
  function automatic logic [15:0] lin(int x, int x0, int x1, int y0, int y1);
    if (x <= x0) return y0[15:0];
    if (x >= x1) return y1[15:0];
    return 16'(y0 + (x - x0) * (y1 - y0) / (x1 - x0));
  endfunction : lin

  task automatic duty(input int v, input logic [15:0] e);
    exp_q.push_back({v >= 9800, v <= 200, e});
    host_i.send(1'b0, 16'(v));
    while (exp_q.size() != 0) @(posedge clk_sys);
  endtask : duty

  task automatic pos(input int p, input int efb, input int x0, input int x1);
    host_i.send(1'b1, 16'(p));
    // busy only rises once the job leaves idle, one edge after the sample
    @(posedge clk_sys);
    rd = 32'h8;
    while (rd[ST_BUSY] !== 1'b0) ahb(1'b0, {25'h0, IX_STATUS, 2'h0}, 0, rd);
    chk({16'h0, fb}, efb);
    chk({16'h0, ao_mv}, {16'h0, lin(efb, x0, x1, 500, 4500)});
  endtask : pos

  // result pulse compared with the oldest note
  always @(negedge clk_sys) begin
    if (demand_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, demand, 16'h0);
      end else begin
        chk({14'h0, flt_hi, flt_lo, demand},
            {14'h0, exp_q.pop_front()});
      end
    end
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    seed = 20860;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < NCFG; i++) begin
      rdchk(5'(i), {16'h0, CFG_RESET[i]});
    end
    rdchk(IX_STATUS, 32'h0);
    ahb(1'b1, 32'h7C, 32'h1234, rd);
    ahb(1'b0, 32'h7C, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test defaults done");
    wr(IX_DUTY_LO, 32'h0);
    rdchk(IX_DUTY_LO, 32'h01F4);
    wr(IX_FLT_HI, 32'hFFFF_FFFF);
    rdchk(IX_FLT_HI, 32'h2648);
    wr(IX_DUTY_LO, 32'h03E8);
    $display("test saturation done");
    foreach (duty_pts[k]) begin
      d = duty_pts[k];
      duty(d, lin(d, 1000, 9000, 0, 10000));
    end
    repeat (8) begin
      d = 500 + int'($unsigned($random(seed)) % 9001);
      duty(d, lin(d, 1000, 9000, 0, 10000));
    end
    $display("test duty mapping done");
    pos(5000, 5000, 0, 10000);
    wr(IX_AOP_LO, 32'd2000);
    wr(IX_AOP_HI, 32'd6000);
    pos(1000, 1000, 2000, 6000);
    pos(8000, 8000, 2000, 6000);
    pos(4000, 4000, 2000, 6000);
    $display("test analog output done");
    wr(IX_CV0 + 5'h01, 32'd4000);
    wr(IX_CTRL, 32'h1);
    foreach (curve_pts[k]) begin
      d = curve_pts[k];
      dm = lin(d, 1000, 9000, 0, 10000);
      duty(d, dm <= 2500 ? lin(dm, 0, 2500, 0, 4000)
                         : lin(dm, 2500, 5000, 4000, 5000));
    end
    pos(4000, 2500, 2000, 6000);
    pos(4500, 3750, 2000, 6000);
    $display("test curve done");
    wr(IX_BP0 + 5'h01, 32'h0);
    // error flag is registered one edge after the write lands
    repeat (2) @(posedge clk_sys);
    chk({31'h0, cfg_error}, 32'h1);
    duty(3000, 16'd2500);
    rdchk(IX_STATUS, 32'h4);
    pos(4000, 4000, 2000, 6000);
    wr(IX_BP0 + 5'h01, 32'd2500);
    @(posedge clk_sys);
    rdchk(IX_STATUS, 32'h0);
    duty(3000, 16'd4000);
    $display("test breakpoint order done");
    finish_test();
  end
endmodule : pwm_demand_scaling_and_curve_test
